/* File: pmc_pkg.sv */
// Package with power mode controller constants, register map and mode encodings
package pmc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register indices
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
	localparam logic [3:0] ADDR_OPTIONS = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	// Control one fields
	localparam int BIT_LVD_ENABLE = 0;
	localparam int BIT_LVD_IN_STOP = 1;
	localparam int BIT_LVD_RESET_SEL = 2;
	// Control two fields
	localparam int BIT_PPD_SELECT = 0;
	localparam int BIT_LPR_REQUEST = 1;
	localparam int BIT_LPR_STATUS = 2;
	localparam int BIT_WAKE_FULL = 3;
	// Options fields
	localparam int BIT_STOP_ENABLE = 0;
	// Reset values
	localparam logic [7:0] RESET_CTRL_ONE = 8'h01;
	localparam logic [7:0] RESET_CTRL_TWO = 8'h00;
	localparam logic [7:0] RESET_OPTIONS = 8'h01;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Mode encoding, Gray along run, lprun, lpwait, stop3, stop2
	typedef enum logic [2:0] {
		MODE_RUN = 3'h0,
		MODE_LPRUN = 3'h1,
		MODE_LPWAIT = 3'h3,
		MODE_STOP3 = 3'h2,
		MODE_STOP2 = 3'h6,
		MODE_WAIT = 3'h4
	} pmc_mode_type;
	// Regulator state encoding
	localparam logic [1:0] REG_FULL = 2'h0;
	localparam logic [1:0] REG_STANDBY = 2'h1;
	localparam logic [1:0] REG_PARTIAL = 2'h2;
endpackage : pmc_pkg

/* File: pmc_regs.sv */
// Register file for power management control bits
`timescale 1ns/100ps
module pmc_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [pmc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pmc_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic clearLowPower,
	input wire logic lprStatusIn,
	input wire logic [2:0] modeIn,
	output logic [pmc_pkg::DATA_W-1:0] regRdata,
	output logic lvdEnable,
	output logic lvdInStop,
	output logic lvdResetSel,
	output logic ppdSelect,
	output logic lprRequest,
	output logic wakeFull,
	output logic stopEnable
);
	logic [pmc_pkg::DATA_W-1:0] ctrlOne;
	logic [pmc_pkg::DATA_W-1:0] ctrlTwo;
	logic [pmc_pkg::DATA_W-1:0] options;
	logic [pmc_pkg::DATA_W-1:0] readMux;
	logic wrOne;
	logic wrTwo;
	logic wrOpt;
	logic next_ppd;
	logic next_lpr;
	logic [pmc_pkg::DATA_W-1:0] ctrlTwoView;

	assign wrOne = regWr && regAddr == pmc_pkg::ADDR_CTRL_ONE;
	assign wrTwo = regWr && regAddr == pmc_pkg::ADDR_CTRL_TWO;
	assign wrOpt = regWr && regAddr == pmc_pkg::ADDR_OPTIONS;
	// A bit can only be set while its partner is clear, checked against the stored value
	assign next_ppd = regWdata[pmc_pkg::BIT_PPD_SELECT] && !ctrlTwo[pmc_pkg::BIT_LPR_REQUEST];
	assign next_lpr = regWdata[pmc_pkg::BIT_LPR_REQUEST] && !ctrlTwo[pmc_pkg::BIT_PPD_SELECT];
	assign ctrlTwoView = {ctrlTwo[7:3], lprStatusIn, ctrlTwo[1:0]};
	assign readMux = (regAddr == pmc_pkg::ADDR_CTRL_ONE) ? ctrlOne :
		(regAddr == pmc_pkg::ADDR_CTRL_TWO) ? ctrlTwoView :
		(regAddr == pmc_pkg::ADDR_OPTIONS) ? options :
		(regAddr == pmc_pkg::ADDR_STATUS) ? {5'h00, modeIn} : pmc_pkg::READ_UNMAPPED;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrlOne <= pmc_pkg::RESET_CTRL_ONE;
			ctrlTwo <= pmc_pkg::RESET_CTRL_TWO;
			options <= pmc_pkg::RESET_OPTIONS;
			regRdata <= pmc_pkg::READ_UNMAPPED;
		end else if (clkEn) begin
			regRdata <= regRd ? readMux : pmc_pkg::READ_UNMAPPED;
			if (wrOne)
				ctrlOne <= {5'h00, regWdata[2:0]};
			if (wrOpt)
				options <= {7'h00, regWdata[pmc_pkg::BIT_STOP_ENABLE]};
			if (clearLowPower)
				ctrlTwo[pmc_pkg::BIT_LPR_REQUEST] <= 1'b0;
			else if (wrTwo) begin
				ctrlTwo[pmc_pkg::BIT_PPD_SELECT] <= next_ppd;
				ctrlTwo[pmc_pkg::BIT_LPR_REQUEST] <= next_lpr;
				ctrlTwo[pmc_pkg::BIT_WAKE_FULL] <= regWdata[pmc_pkg::BIT_WAKE_FULL];
			end
		end
	end

	assign lvdEnable = ctrlOne[pmc_pkg::BIT_LVD_ENABLE];
	assign lvdInStop = ctrlOne[pmc_pkg::BIT_LVD_IN_STOP];
	assign lvdResetSel = ctrlOne[pmc_pkg::BIT_LVD_RESET_SEL];
	assign ppdSelect = ctrlTwo[pmc_pkg::BIT_PPD_SELECT];
	assign lprRequest = ctrlTwo[pmc_pkg::BIT_LPR_REQUEST];
	assign wakeFull = ctrlTwo[pmc_pkg::BIT_WAKE_FULL];
	assign stopEnable = options[pmc_pkg::BIT_STOP_ENABLE];

	a_ppd_lpr_exclusive: assert property (@(posedge sys_clk) disable iff (rst) !(ppdSelect && lprRequest))
		else $error("partial powerdown and low power run both set");
endmodule : pmc_regs

/* File: pmc_lvd.sv */
// Low-voltage event steering to interrupt or reset
`timescale 1ns/100ps
module pmc_lvd (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic lvdEnable,
	input wire logic lvdResetSel,
	input wire logic supplyLow,
	output logic lvdIrq,
	output logic lvdReset
);
	logic lowSeen;
	logic lowEdge;

	// Edge so that a long brown-out raises one event, not a stream
	assign lowEdge = supplyLow && !lowSeen && lvdEnable;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lowSeen <= 1'b0;
			lvdIrq <= 1'b0;
			lvdReset <= 1'b0;
		end else if (clkEn) begin
			lowSeen <= supplyLow;
			lvdIrq <= lowEdge && !lvdResetSel;
			lvdReset <= lowEdge && lvdResetSel;
		end
	end

	a_lvd_reset_path: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && lvdEnable && lvdResetSel && supplyLow && !lowSeen |=> lvdReset && !lvdIrq)
		else $error("low voltage reset not raised");
endmodule : pmc_lvd

/* File: pmc_mode_ctrl.sv */
// Power mode controller top: mode selection, transitions and subsystem controls
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module pmc_mode_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [pmc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pmc_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [pmc_pkg::DATA_W-1:0] regRdata,
	input wire logic debugEnable,
	input wire logic stopInstr,
	input wire logic waitInstr,
	input wire logic intPending,
	input wire logic resetPinLow,
	input wire logic wakePinLow,
	input wire logic rtcIrq,
	input wire logic supplyLow,
	output logic [2:0] modeState,
	output logic [1:0] regulatorState,
	output logic cpuClkEn,
	output logic periphClkEn,
	output logic periphSlowClk,
	output logic debugClkEn,
	output logic lowFreqClkEn,
	output logic clockLowPower,
	output logic periphPowerDown,
	output logic displayPowered,
	output logic lowPowerStatus,
	output logic illegalOpReset,
	output logic stop2Wake,
	output logic lvdIrq,
	output logic lvdReset
);
	pmc_pkg::pmc_mode_type mode;
	pmc_pkg::pmc_mode_type next_mode;
	pmc_pkg::pmc_mode_type stopTarget;
	logic lvdEnable;
	logic lvdInStop;
	logic lvdResetSel;
	logic ppdSelect;
	logic lprRequest;
	logic wakeFull;
	logic stopEnable;
	logic bothLvd;
	logic lpRunAllowed;
	logic stop2Allowed;
	logic stop2Exit;
	logic clearLowPower;
	logic lowPowerBit;
	logic regOn;
	logic next_cpuClk;
	logic next_periphClk;
	logic next_slow;
	logic next_debugClk;
	logic next_lfClk;
	logic next_clkLp;
	logic next_pd;
	logic [1:0] next_regulator;
	logic next_illegal;

	pmc_regs u_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(clkEn),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWr(regWr),
		.regRd(regRd),
		.clearLowPower(clearLowPower),
		.lprStatusIn(lowPowerBit),
		.modeIn(mode),
		.regRdata(regRdata),
		.lvdEnable(lvdEnable),
		.lvdInStop(lvdInStop),
		.lvdResetSel(lvdResetSel),
		.ppdSelect(ppdSelect),
		.lprRequest(lprRequest),
		.wakeFull(wakeFull),
		.stopEnable(stopEnable)
	);

	pmc_lvd u_lvd (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(clkEn),
		.lvdEnable(lvdEnable),
		.lvdResetSel(lvdResetSel),
		.supplyLow(supplyLow),
		.lvdIrq(lvdIrq),
		.lvdReset(lvdReset)
	);

	// Debug enable is an input only; the debug port owns it, software cannot write it
	assign bothLvd = lvdEnable && lvdInStop;
	assign lpRunAllowed = !debugEnable && lprRequest && !ppdSelect && !bothLvd;
	assign stop2Allowed = !debugEnable && !lprRequest && ppdSelect && !bothLvd;
	assign stop2Exit = resetPinLow || wakePinLow || rtcIrq;
	// Stop target is fixed at the instruction; low-power run can only go to stop3
	assign stopTarget = (mode == pmc_pkg::MODE_RUN && stop2Allowed) ? pmc_pkg::MODE_STOP2 : pmc_pkg::MODE_STOP3;
	assign lowPowerBit = (mode == pmc_pkg::MODE_LPRUN) || (mode == pmc_pkg::MODE_LPWAIT) ||
		(mode == pmc_pkg::MODE_STOP3 && lprRequest);
	// Interrupt wake from a low-power origin with full regulation drops the request
	assign clearLowPower = clkEn && intPending && wakeFull && lprRequest &&
		(mode == pmc_pkg::MODE_STOP3 || mode == pmc_pkg::MODE_LPWAIT);
	assign next_illegal = stopInstr && !stopEnable &&
		(mode == pmc_pkg::MODE_RUN || mode == pmc_pkg::MODE_LPRUN);

	always_comb begin
		next_mode = mode;
		case (mode)
			pmc_pkg::MODE_RUN: begin
				if (stopInstr && stopEnable)
					next_mode = stopTarget;
				else if (waitInstr)
					next_mode = pmc_pkg::MODE_WAIT;
				else if (lpRunAllowed)
					next_mode = pmc_pkg::MODE_LPRUN;
			end
			pmc_pkg::MODE_LPRUN: begin
				if (!lpRunAllowed)
					next_mode = pmc_pkg::MODE_RUN;
				else if (stopInstr && stopEnable)
					next_mode = pmc_pkg::MODE_STOP3;
				else if (waitInstr)
					next_mode = pmc_pkg::MODE_LPWAIT;
			end
			pmc_pkg::MODE_LPWAIT: begin
				if (intPending)
					next_mode = wakeFull ? pmc_pkg::MODE_RUN : pmc_pkg::MODE_LPRUN;
			end
			pmc_pkg::MODE_WAIT: begin
				if (intPending)
					next_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_STOP3: begin
				if (intPending)
					next_mode = (lprRequest && !wakeFull) ? pmc_pkg::MODE_LPRUN : pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_STOP2: begin
				if (stop2Exit)
					next_mode = pmc_pkg::MODE_RUN;
			end
			default: next_mode = pmc_pkg::MODE_RUN;
		endcase
	end

	// Subsystem controls decoded from the next mode so outputs align with the mode register
	assign regOn = bothLvd || debugEnable;
	assign next_cpuClk = next_mode == pmc_pkg::MODE_RUN || next_mode == pmc_pkg::MODE_LPRUN;
	assign next_periphClk = next_cpuClk || next_mode == pmc_pkg::MODE_WAIT || next_mode == pmc_pkg::MODE_LPWAIT;
	assign next_slow = next_mode == pmc_pkg::MODE_LPRUN || next_mode == pmc_pkg::MODE_LPWAIT;
	assign next_clkLp = next_slow;
	assign next_debugClk = debugEnable && !next_slow && next_mode != pmc_pkg::MODE_STOP2;
	assign next_lfClk = debugEnable && next_mode == pmc_pkg::MODE_STOP3;
	assign next_pd = next_mode == pmc_pkg::MODE_STOP2;
	assign next_regulator = (next_mode == pmc_pkg::MODE_STOP2) ? pmc_pkg::REG_PARTIAL :
		(next_slow || (next_mode == pmc_pkg::MODE_STOP3 && !regOn)) ? pmc_pkg::REG_STANDBY :
		pmc_pkg::REG_FULL;

	// Any reset returns to run; stop3 and low-power state are dropped with it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode <= pmc_pkg::MODE_RUN;
			modeState <= 3'h0;
			regulatorState <= pmc_pkg::REG_FULL;
			cpuClkEn <= 1'b1;
			periphClkEn <= 1'b1;
			periphSlowClk <= 1'b0;
			debugClkEn <= 1'b0;
			lowFreqClkEn <= 1'b0;
			clockLowPower <= 1'b0;
			periphPowerDown <= 1'b0;
			displayPowered <= 1'b1;
			lowPowerStatus <= 1'b0;
			illegalOpReset <= 1'b0;
			stop2Wake <= 1'b0;
		end else if (clkEn) begin
			mode <= next_mode;
			modeState <= next_mode;
			regulatorState <= next_regulator;
			cpuClkEn <= next_cpuClk;
			periphClkEn <= next_periphClk;
			periphSlowClk <= next_slow;
			debugClkEn <= next_debugClk;
			lowFreqClkEn <= next_lfClk;
			clockLowPower <= next_clkLp;
			periphPowerDown <= next_pd;
			displayPowered <= 1'b1; // Display survives every mode, stop2 included
			lowPowerStatus <= next_slow;
			illegalOpReset <= next_illegal;
			stop2Wake <= mode == pmc_pkg::MODE_STOP2 && stop2Exit;
		end
	end

	// Assertions
	sequence s_stop_in_lprun;
		mode == pmc_pkg::MODE_LPRUN && stopInstr && stopEnable && lpRunAllowed && clkEn;
	endsequence
	sequence s_stop3_int;
		mode == pmc_pkg::MODE_STOP3 && intPending && clkEn;
	endsequence

	a_no_stop2_lprun: assert property (@(posedge sys_clk) disable iff (rst)
		mode == pmc_pkg::MODE_LPRUN |=> mode != pmc_pkg::MODE_STOP2)
		else $error("stop2 entered from low power run");
	a_lprun_stop3: assert property (@(posedge sys_clk) disable iff (rst)
		s_stop_in_lprun |=> mode == pmc_pkg::MODE_STOP3)
		else $error("stop in low power run did not reach stop3");
	a_stop3_wake_lp: assert property (@(posedge sys_clk) disable iff (rst)
		s_stop3_int ##0 (lprRequest && !wakeFull) |=> mode == pmc_pkg::MODE_LPRUN)
		else $error("stop3 interrupt did not return to low power run");
	a_stop3_wake_full: assert property (@(posedge sys_clk) disable iff (rst)
		s_stop3_int ##0 (lprRequest && wakeFull) |=> mode == pmc_pkg::MODE_RUN && !lprRequest)
		else $error("full regulation wake did not clear request");
	a_stop2_select: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(mode) && mode == pmc_pkg::MODE_STOP2 |-> !$past(bothLvd) && !$past(debugEnable))
		else $error("stop2 entered with debug or lvd in stop");
	a_stop2_exit: assert property (@(posedge sys_clk) disable iff (rst)
		mode == pmc_pkg::MODE_STOP2 && clkEn && !stop2Exit |=> mode == pmc_pkg::MODE_STOP2)
		else $error("stop2 left without a wake source");
	a_stop3_regulator: assert property (@(posedge sys_clk) disable iff (rst)
		mode == pmc_pkg::MODE_STOP3 && $stable(mode) && $stable(regOn) |->
		regulatorState == (regOn ? pmc_pkg::REG_FULL : pmc_pkg::REG_STANDBY))
		else $error("stop3 regulator state wrong");
	a_lpwait_clocks: assert property (@(posedge sys_clk) disable iff (rst)
		mode == pmc_pkg::MODE_LPWAIT |-> !cpuClkEn && periphSlowClk && !debugClkEn &&
		regulatorState == pmc_pkg::REG_STANDBY)
		else $error("low power wait outputs wrong");
	a_wait_clocks: assert property (@(posedge sys_clk) disable iff (rst)
		mode == pmc_pkg::MODE_WAIT |-> !cpuClkEn && periphClkEn && regulatorState == pmc_pkg::REG_FULL)
		else $error("wait outputs wrong");
	a_illegal_stop: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && stopInstr && !stopEnable && mode == pmc_pkg::MODE_RUN |=> illegalOpReset && mode == pmc_pkg::MODE_RUN)
		else $error("disabled stop did not force reset");
	a_lpr_clear_run: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && mode == pmc_pkg::MODE_LPRUN && !lprRequest |=> mode == pmc_pkg::MODE_RUN)
		else $error("clearing request did not return to run");
endmodule : pmc_mode_ctrl

/* File: pmc_cpu_model.sv */
// CPU core model: register bus master and stop/wait instruction source
`timescale 1ns/100ps
module pmc_cpu_model (
	input wire logic sys_clk,
	input wire logic [pmc_pkg::DATA_W-1:0] regRdata,
	output logic [pmc_pkg::ADDR_W-1:0] regAddr,
	output logic [pmc_pkg::DATA_W-1:0] regWdata,
	output logic regWr,
	output logic regRd,
	output logic stopInstr,
	output logic waitInstr
);
	initial begin
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		stopInstr = 1'b0;
		waitInstr = 1'b0;
	end
	// Idle address and data are inverted so a stale value never looks valid
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdata;
	endtask : rd
	// One-cycle completion pulse of a stop or wait instruction
	task automatic instr(input logic isStop);
		@(posedge sys_clk);
		stopInstr <= isStop;
		waitInstr <= !isStop;
		@(posedge sys_clk);
		stopInstr <= 1'b0;
		waitInstr <= 1'b0;
	endtask : instr
endmodule : pmc_cpu_model

/* File: test_pmc_mode_ctrl.sv */
// Self-checking testbench for the power mode controller
`timescale 1ns/100ps
module test_pmc_mode_ctrl;
	logic sys_clk = 1'b0;
	logic rst;
	logic clkEn;
	logic debugEnable;
	logic intPending;
	logic resetPinLow;
	logic wakePinLow;
	logic rtcIrq;
	logic supplyLow;
	logic [3:0] regAddr;
	logic [7:0] regWdata;
	logic regWr;
	logic regRd;
	logic stopInstr;
	logic waitInstr;
	logic [7:0] regRdata;
	logic [2:0] modeState;
	logic [1:0] regulatorState;
	logic cpuClkEn, periphClkEn, periphSlowClk, debugClkEn, lowFreqClkEn, clockLowPower;
	logic periphPowerDown, displayPowered, lowPowerStatus, illegalOpReset, stop2Wake, lvdIrq, lvdReset;
	logic [3:0] pulses;
	logic [7:0] rdv;
	int n_mismatch = 0;
	int n_checks = 0;
	assign pulses = {lvdReset, lvdIrq, stop2Wake, illegalOpReset};
	always #2.5 sys_clk = ~sys_clk;
	pmc_mode_ctrl u_pmc_mode_ctrl (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .debugEnable(debugEnable),
		.stopInstr(stopInstr), .waitInstr(waitInstr), .intPending(intPending), .resetPinLow(resetPinLow),
		.wakePinLow(wakePinLow), .rtcIrq(rtcIrq), .supplyLow(supplyLow), .modeState(modeState),
		.regulatorState(regulatorState), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
		.periphSlowClk(periphSlowClk), .debugClkEn(debugClkEn), .lowFreqClkEn(lowFreqClkEn),
		.clockLowPower(clockLowPower), .periphPowerDown(periphPowerDown), .displayPowered(displayPowered),
		.lowPowerStatus(lowPowerStatus), .illegalOpReset(illegalOpReset), .stop2Wake(stop2Wake),
		.lvdIrq(lvdIrq), .lvdReset(lvdReset));
	pmc_cpu_model u_pmc_cpu_model (.sys_clk(sys_clk), .regRdata(regRdata), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .stopInstr(stopInstr), .waitInstr(waitInstr));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
		u_pmc_cpu_model.rd(a, rdv);
		chk(rdv, exp);
	endtask : rdChk
	task automatic modeChk(input logic [2:0] m, input logic [1:0] r);
		repeat (3) @(posedge sys_clk);
		#1;
		chk({5'h0, modeState}, {5'h0, m});
		chk({6'h0, regulatorState}, {6'h0, r});
	endtask : modeChk
	// Looks over four cycles, so the pulse latency is not pinned down here
	task automatic seePulse(input int idx);
		logic found;
		found = 1'b0;
		for (int k = 0; k < 4; k++) begin
			#1;
			if (pulses[idx] === 1'b1) found = 1'b1;
			@(posedge sys_clk);
		end
		chk({7'h0, found}, 8'h01);
	endtask : seePulse
	task automatic irq();
		@(posedge sys_clk);
		intPending <= 1'b1;
		@(posedge sys_clk);
		intPending <= 1'b0;
	endtask : irq
	task automatic t_reset();
		rdChk(pmc_pkg::ADDR_CTRL_ONE, pmc_pkg::RESET_CTRL_ONE);
		rdChk(pmc_pkg::ADDR_CTRL_TWO, pmc_pkg::RESET_CTRL_TWO);
		rdChk(pmc_pkg::ADDR_OPTIONS, pmc_pkg::RESET_OPTIONS);
		rdChk(pmc_pkg::ADDR_STATUS, 8'h00);
		rdChk(4'h9, pmc_pkg::READ_UNMAPPED);
		chk({displayPowered, cpuClkEn, periphClkEn}, 8'h07);
	endtask : t_reset
	task automatic t_lprun();
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h01);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h03);
		rdChk(pmc_pkg::ADDR_CTRL_TWO, 8'h01);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h00);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h02); // request written last
		modeChk(pmc_pkg::MODE_LPRUN, pmc_pkg::REG_STANDBY);
		chk({debugClkEn, clockLowPower, lowPowerStatus}, 8'h03);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h03);
		rdChk(pmc_pkg::ADDR_CTRL_TWO, 8'h06);
		u_pmc_cpu_model.instr(1'b0);
		modeChk(pmc_pkg::MODE_LPWAIT, pmc_pkg::REG_STANDBY);
		chk({cpuClkEn, periphSlowClk, clockLowPower, debugClkEn}, 8'h06);
		irq();
		modeChk(pmc_pkg::MODE_LPRUN, pmc_pkg::REG_STANDBY);
		u_pmc_cpu_model.instr(1'b1);
		modeChk(pmc_pkg::MODE_STOP3, pmc_pkg::REG_STANDBY);
		irq();
		modeChk(pmc_pkg::MODE_LPRUN, pmc_pkg::REG_STANDBY);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h00);
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		chk({7'h0, lowPowerStatus}, 8'h00);
	endtask : t_lprun
	task automatic t_wakefull();
		for (int i = 0; i < 2; i++) begin
			u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h0a);
			modeChk(pmc_pkg::MODE_LPRUN, pmc_pkg::REG_STANDBY);
			u_pmc_cpu_model.instr(i == 0);
			modeChk(i == 0 ? pmc_pkg::MODE_STOP3 : pmc_pkg::MODE_LPWAIT, pmc_pkg::REG_STANDBY);
			irq();
			modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
			rdChk(pmc_pkg::ADDR_CTRL_TWO, 8'h08);
		end
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h01);
	endtask : t_wakefull
	task automatic t_stop2();
		for (int i = 0; i < 3; i++) begin
			u_pmc_cpu_model.instr(1'b1);
			modeChk(pmc_pkg::MODE_STOP2, pmc_pkg::REG_PARTIAL);
			chk({cpuClkEn, periphClkEn, periphPowerDown, displayPowered}, 8'h03);
			irq();
			modeChk(pmc_pkg::MODE_STOP2, pmc_pkg::REG_PARTIAL);
			@(posedge sys_clk);
			wakePinLow <= (i == 0);
			rtcIrq <= (i == 1);
			resetPinLow <= (i == 2);
			seePulse(1);
			wakePinLow <= 1'b0;
			rtcIrq <= 1'b0;
			resetPinLow <= 1'b0;
			modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		end
	endtask : t_stop2
	task automatic t_stop3sel();
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_ONE, 8'h03);
		u_pmc_cpu_model.instr(1'b1);
		modeChk(pmc_pkg::MODE_STOP3, pmc_pkg::REG_FULL);
		irq();
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_ONE, 8'h01);
		@(posedge sys_clk);
		debugEnable <= 1'b1; // only the debug host drives this level
		u_pmc_cpu_model.instr(1'b1);
		modeChk(pmc_pkg::MODE_STOP3, pmc_pkg::REG_FULL);
		chk({debugClkEn, lowFreqClkEn}, 8'h03);
		irq();
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		u_pmc_cpu_model.instr(1'b0);
		modeChk(pmc_pkg::MODE_WAIT, pmc_pkg::REG_FULL);
		chk({cpuClkEn, periphClkEn, debugClkEn, clockLowPower}, 8'h06);
		irq();
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		@(posedge sys_clk);
		debugEnable <= 1'b0;
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h00);
	endtask : t_stop3sel
	task automatic t_illegal();
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_OPTIONS, 8'h00);
		u_pmc_cpu_model.instr(1'b1);
		seePulse(0);
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_OPTIONS, 8'h01);
	endtask : t_illegal
	task automatic t_lvd();
		for (int i = 0; i < 2; i++) begin
			u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_ONE, i == 0 ? 8'h01 : 8'h05);
			@(posedge sys_clk);
			supplyLow <= 1'b1;
			seePulse(2 + i);
			supplyLow <= 1'b0;
		end
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_ONE, 8'h01);
	endtask : t_lvd
	// Frozen clock enable must drop both a register write and a stop instruction
	task automatic t_freeze();
		@(posedge sys_clk);
		clkEn <= 1'b0;
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h02);
		u_pmc_cpu_model.instr(1'b1);
		clkEn <= 1'b1;
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		rdChk(pmc_pkg::ADDR_CTRL_TWO, 8'h00);
	endtask : t_freeze
	// Mid-run reset while stopped from low-power run
	task automatic t_rststop();
		u_pmc_cpu_model.wr(pmc_pkg::ADDR_CTRL_TWO, 8'h02);
		modeChk(pmc_pkg::MODE_LPRUN, pmc_pkg::REG_STANDBY);
		u_pmc_cpu_model.instr(1'b1);
		modeChk(pmc_pkg::MODE_STOP3, pmc_pkg::REG_STANDBY);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		modeChk(pmc_pkg::MODE_RUN, pmc_pkg::REG_FULL);
		rdChk(pmc_pkg::ADDR_CTRL_TWO, pmc_pkg::RESET_CTRL_TWO);
	endtask : t_rststop
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	// The full sequence needs well under 2000 cycles
	initial begin
		#50000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		rst <= 1'b1;
		clkEn <= 1'b1;
		debugEnable <= 1'b0;
		intPending <= 1'b0;
		resetPinLow <= 1'b0;
		wakePinLow <= 1'b0;
		rtcIrq <= 1'b0;
		supplyLow <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_lprun();
		t_wakefull();
		t_stop2();
		t_stop3sel();
		t_illegal();
		t_lvd();
		t_freeze();
		t_rststop();
		wrap_up();
	end
endmodule : test_pmc_mode_ctrl
